/* File: pbpc_counters.sv */
// Purpose: per-bundle rx/tx good packet and rx lost/jump counters
// Assumes: event inputs come from logic on clk; host strobes are synchronous to clk
// Notes: one read strobe per host cycle; read data is registered one cycle later
// Operation
// RULE1 - plain window read leaves counter unchanged
// RULE2 - clear window read returns then clears
// RULE3 - 16-bit read at bit1 latches, gives low
// RULE4 - following bit1-clear read gives latched high half
// RULE5 - 64 bundles, address base plus index times four
// RULE6 - rx good counter 32-bit, wraps
// RULE7 - tx good counter 32-bit, wraps
// RULE8 - aal1/satop add gap unless above limit
// RULE9 - hdlc adds difference only below 32768
// RULE10 - lost counter upper sixteen bits read zero
// RULE11 - increment during clear survives the clear
`timescale 1ns/1ns
module pbpc_counters #(
  parameter int NB = pbpc_pkg::BUNDLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic bus16,
  input wire logic rd,
  input wire logic [16:0] addr,
  output logic [31:0] rdata,
  output logic rvalid,
  input wire logic rx_good,
  input wire logic [5:0] rx_good_bundle,
  input wire logic tx_good,
  input wire logic [5:0] tx_good_bundle,
  input wire logic seq_ev,
  input wire logic [5:0] seq_bundle,
  input wire logic [1:0] seq_mode,
  input wire logic [15:0] seq_rx,
  input wire logic [15:0] seq_exp,
  input wire logic [15:0] max_lost
);
  // counter values: one word per bundle for each counter kind
  logic [31:0] rx_cnt [NB];
  logic [31:0] tx_cnt [NB];
  logic [15:0] lost_cnt [NB];

  // capture for the split 16-bit read; only a bit1-set read loads it
  logic [31:0] latch;
  logic [31:0] next_latch;
  logic [31:0] next_rdata;

  // address fields
  wire [4:0] win_sel;
  wire [3:0] kind_sel;
  wire [5:0] idx;
  wire idx_ok;
  wire in_plain;
  wire in_clr;
  wire in_window;

  // counter kind hits
  wire hit_rx;
  wire hit_tx;
  wire hit_lost;
  wire hit_any;

  // read flavours
  wire take;
  wire lo_read;
  wire hi_read;
  wire whole_read;
  wire do_clr;

  // selected counter words and outgoing halves
  wire [31:0] rx_word;
  wire [31:0] tx_word;
  wire [31:0] lost_word;
  wire [31:0] cur;
  wire [31:0] lo_half;
  wire [31:0] hi_half;

  // read data candidates, one per read flavour
  wire [31:0] lo_word;
  wire [31:0] hi_word;
  wire [31:0] whole_word;

  // sequence gap qualification
  wire [15:0] gap;
  wire is_hdlc;
  wire in_hdlc_window;
  wire in_lost_limit;
  wire gap_ok;

  // window decode on bits 16:12; any other window is not ours and reads zero
  assign win_sel = addr[16:12];
  assign in_plain = win_sel == pbpc_pkg::PLAIN_BASE[16:12]; // RULE1
  assign in_clr = win_sel == pbpc_pkg::CLR_BASE[16:12]; // RULE2
  assign in_window = in_plain || in_clr;

  // bits 11:8 pick the counter kind, bits 7:2 the bundle
  assign kind_sel = addr[11:8];
  assign idx = addr[7:2]; // RULE5
  // a build with fewer bundles must not index past its arrays
  assign idx_ok = int'(idx) < NB; // RULE5

  // kind 0x100 and kinds above 0x300 have no counter here and stay unmatched
  assign hit_rx = idx_ok && kind_sel == pbpc_pkg::RX_GOOD_OFS[11:8]; // RULE6
  assign hit_tx = idx_ok && kind_sel == pbpc_pkg::TX_GOOD_OFS[11:8]; // RULE7
  assign hit_lost = idx_ok && kind_sel == pbpc_pkg::LOST_OFS[11:8]; // RULE8
  // any real counter under this address
  assign hit_any = hit_rx || hit_tx || hit_lost;

  // a strobe inside either window is a counter read
  assign take = rd && in_window;

  // 16-bit mode: bit1 set loads the capture, bit1 clear replays its top half
  assign lo_read = take && bus16 && addr[1]; // RULE3
  assign hi_read = take && bus16 && !addr[1]; // RULE4
  assign whole_read = take && !bus16; // RULE1

  // the top-half read works from the capture, so it must never clear:
  // a clear there would drop counts taken after the low-half read
  assign do_clr = take && in_clr && hit_any && !hi_read; // RULE2

  // word select; the lost counter's upper half is reserved and reads zero
  assign rx_word = hit_rx ? rx_cnt[idx] : 32'h0000_0000;
  assign tx_word = hit_tx ? tx_cnt[idx] : 32'h0000_0000;
  assign lost_word = hit_lost ? {16'h0000, lost_cnt[idx]} : 32'h0000_0000; // RULE10
  // at most one kind hits, so an or is enough
  assign cur = rx_word | tx_word | lost_word;

  // halves as they go out on a 16-bit bus, upper lanes held at zero
  assign lo_half = {16'h0000, cur[15:0]}; // RULE3
  assign hi_half = {16'h0000, latch[31:16]}; // RULE4

  // gap modulo 2^16, so a sequence number wrap still gives the true distance
  assign gap = seq_rx - seq_exp;
  assign is_hdlc = seq_mode == pbpc_pkg::PBPC_HDLC;
  // hdlc: only differences inside the half-range window count
  assign in_hdlc_window = gap < pbpc_pkg::HDLC_WINDOW; // RULE9
  // aal1 and satop: a jump above the configured limit is not counted
  assign in_lost_limit = gap <= max_lost; // RULE8
  // the unused mode code falls back to the limit test
  assign gap_ok = is_hdlc ? in_hdlc_window : in_lost_limit;

  // one cell per bundle and kind; the cell puts an increment on top of a clear,
  // so a count that lands during a clear-on-read is never lost

  // good packets received: 32 bits, wraps to zero
  for (genvar gi = 0; gi < NB; gi++) begin : g_rx
    wire here;
    wire hit;
    wire clr;
    wire inc;
    wire [31:0] step;

    // clear only the counter read out of the clear window
    assign here = idx == 6'(gi);
    assign hit = here && hit_rx;
    assign clr = do_clr && hit; // RULE2

    // event strobes come from logic on clk: no synchroniser needed
    assign inc = rx_good && rx_good_bundle == 6'(gi); // RULE6
    assign step = 32'h0000_0001;

    // counter cell for this bundle
    pbpc_cell #(
      .W(32)
    ) u_cell (
      .clk(clk),
      .nrst(nrst),
      .clr(clr),
      .inc(inc),
      .amount(step),
      .value(rx_cnt[gi])
    );
  end

  // good packets sent: 32 bits, wraps to zero
  for (genvar gi = 0; gi < NB; gi++) begin : g_tx
    wire here;
    wire hit;
    wire clr;
    wire inc;
    wire [31:0] step;

    // clear only the counter read out of the clear window
    assign here = idx == 6'(gi);
    assign hit = here && hit_tx;
    assign clr = do_clr && hit; // RULE2

    // event strobes come from logic on clk: no synchroniser needed
    assign inc = tx_good && tx_good_bundle == 6'(gi); // RULE7
    assign step = 32'h0000_0001;

    // counter cell for this bundle
    pbpc_cell #(
      .W(32)
    ) u_cell (
      .clk(clk),
      .nrst(nrst),
      .clr(clr),
      .inc(inc),
      .amount(step),
      .value(tx_cnt[gi])
    );
  end

  // lost or jumped packets: 16 bits, adds the qualified gap
  for (genvar gi = 0; gi < NB; gi++) begin : g_lost
    wire here;
    wire hit;
    wire clr;
    wire inc;
    wire [15:0] step;

    // clear only the counter read out of the clear window
    assign here = idx == 6'(gi);
    assign hit = here && hit_lost;
    assign clr = do_clr && hit; // RULE2

    // event strobes come from logic on clk: no synchroniser needed
    assign inc = seq_ev && gap_ok && seq_bundle == 6'(gi); // RULE8 RULE9
    assign step = gap;

    // counter cell for this bundle
    pbpc_cell #(
      .W(16)
    ) u_cell (
      .clk(clk),
      .nrst(nrst),
      .clr(clr),
      .inc(inc),
      .amount(step),
      .value(lost_cnt[gi])
    );
  end

  // each read flavour gives its own word; a miss or no read gives zero
  assign lo_word = lo_read ? lo_half : 32'h0000_0000; // RULE3
  assign hi_word = hi_read ? hi_half : 32'h0000_0000; // RULE4
  assign whole_word = whole_read ? cur : 32'h0000_0000; // RULE1
  assign next_rdata = lo_word | hi_word | whole_word;

  // the capture holds its word until the next bit1-set read
  assign next_latch = lo_read ? cur : latch; // RULE3

  // read data, registered one cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= pbpc_pkg::COUNT_RESET;
    end else begin
      rdata <= next_rdata;
    end
  end

  // answer strobe follows every read strobe, mapped or not
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd;
    end
  end

  // split-read capture
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latch <= pbpc_pkg::COUNT_RESET;
    end else begin
      latch <= next_latch;
    end
  end
endmodule

// one wrapping counter with clear-on-read; a same-cycle increment lands on the cleared value
module pbpc_cell #(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic inc,
  input wire logic [W-1:0] amount,
  output logic [W-1:0] value
);
  // cleared base and next count
  logic [W-1:0] base;
  logic [W-1:0] next_value;

  // a clear drops the old count, the same-cycle event still lands
  assign base = clr ? {W{1'b0}} : value; // RULE11
  // plain modulo add: the counter rolls over to zero past its maximum
  assign next_value = inc ? base + amount : base; // RULE6 RULE7

  // counter register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      value <= W'(pbpc_pkg::COUNT_RESET);
    end else begin
      value <= next_value;
    end
  end
endmodule

/* File: pbpc_host.sv */
// Purpose: host model. Assumes: called at a falling edge. Notes: idle address shows its inverse
`timescale 1ns/1ns
module pbpc_host(input wire logic clk,input wire logic [31:0] rdata,output logic rd,output logic [16:0] addr);
  initial {rd,addr}=0;
  // one read then an idle cycle, so no strobe is set twice at one edge
  task automatic rw(input logic [16:0] a,output logic [31:0] d);
    {rd,addr}={1'b1,a}; @(negedge clk) d=rdata; {rd,addr}={1'b0,~a}; @(negedge clk);
  endtask
  task automatic rw16(input logic [16:0] a,output logic [31:0] d);
    logic [31:0] l,h; rw(a|17'h2,l); rw(a&~17'h2,h); d={h[15:0],l[15:0]};
  endtask
endmodule

/* File: pbpc_pkg.sv */
// Purpose: constants for the per-bundle packet counter bank
// Assumes: host byte addresses, 64 bundles, 16-bit sequence numbers
// Notes: counters live in a plain window and a clear-on-read window
package pbpc_pkg;
  localparam logic [16:0] PLAIN_BASE = 17'h10000;
  localparam logic [16:0] CLR_BASE = 17'h11000;
  localparam logic [11:0] RX_GOOD_OFS = 12'h000;
  localparam logic [11:0] TX_GOOD_OFS = 12'h200;
  localparam logic [11:0] LOST_OFS = 12'h300;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [15:0] HDLC_WINDOW = 16'h8000;
  localparam int BUNDLES = 64;
  typedef enum logic [1:0] {
    PBPC_AAL1 = 2'b00,
    PBPC_SATOP = 2'b01,
    PBPC_HDLC = 2'b10
  } pbpc_mode_t;
endpackage

/* File: pbpc_properties.sv */
// Purpose: port checks. Assumes: one clock. Notes: bind follows the module
`timescale 1ns/1ns
module pbpc_properties(input wire logic clk,nrst,bus16,rd,rvalid,rx_good,tx_good,seq_ev,
  input wire logic [16:0] addr,input wire logic [31:0] rdata);
  wire q=!rx_good&&!tx_good&&!seq_ev; // quiet cycle: no counter moves
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // same address again two cycles on, nothing counted in between
  sequence s_ag; q&&!rd ##1 rd&&!bus16&&addr==$past(addr,2); endsequence
  property p_rv; rd|=>rvalid; endproperty a_rv: assert property(p_rv) else $error("rv");
  property p_nv; !rd|=>!rvalid; endproperty a_nv: assert property(p_nv) else $error("nv");
  property p_z; !rd|=>rdata==0; endproperty a_z: assert property(p_z) else $error("z");
  property p_h; rd&&bus16|=>rdata[31:16]==0; endproperty a_h: assert property(p_h) else $error("h");
  property p_l; rd&&addr[11:8]==4'h3|=>rdata[31:16]==0; endproperty a_l: assert property(p_l) else $error("l");
  property p_o; rd&&addr[16:13]!=4'h8|=>rdata==0; endproperty a_o: assert property(p_o) else $error("o");
  property p_k; rd&&addr[16:12]==5'h10&&!bus16&&q ##1 s_ag|=>rdata==$past(rdata,2); endproperty
  a_k: assert property(p_k) else $error("k");
  property p_c; rd&&addr[16:12]==5'h11&&!bus16&&q ##1 s_ag|=>rdata==0; endproperty
  a_c: assert property(p_c) else $error("c");
  cover property(rd&&bus16); cover property(rd&&addr[12]); cover property(seq_ev);
endmodule
bind pbpc_counters pbpc_properties chk(.*);

/* File: tb.sv */
// Purpose: directed counter reads. Assumes: 100 MHz clk. Notes: inputs move at falling edges
`timescale 1ns/1ns
module tb;
  logic clk=0,nrst=0,bus16=0,rx_good=0,tx_good=0,seq_ev=0,rvalid,rd;
  logic [5:0] rx_good_bundle=0,tx_good_bundle,seq_bundle;
  logic [1:0] seq_mode=0;
  logic [15:0] seq_rx=0,seq_exp=16'h0100,max_lost=16'h000a;
  logic [16:0] addr;
  logic [31:0] rdata,d;
  int errors=0,n_tests=0,cyc=0;
  assign {tx_good_bundle,seq_bundle}={2{rx_good_bundle}}; // one bundle for all events
  pbpc_counters dut(.*);
  pbpc_host h(.*);
  initial forever #5 clk=~clk;
  always @(posedge clk) if(++cyc==1000) begin errors++; final_report; end
  task rc(input logic [16:0] a,input logic [31:0] e);
    if(bus16) h.rw16(a,d); else h.rw(a,d);
    n_tests++; if(d!==e) begin errors++; $display("FAIL %0t %h got %h",$time,a,d); end
  endtask
  task p(input logic [2:0] k); {rx_good,tx_good,seq_ev}=k; @(negedge clk) {rx_good,tx_good,seq_ev}=0; @(negedge clk); endtask
  task sq(input logic [1:0] m,input logic [15:0] g); seq_mode=m; seq_rx=seq_exp+g; p(3'h1); endtask
  task final_report; if(errors==0&&n_tests>0) $display("ALL CHECKS OK"); else $display("CHECKS NOT OK"); $finish; endtask
  initial begin
    repeat(16) @(negedge clk); nrst=1; rx_good_bundle=5; p(3'h4); p(3'h4);
    rc(17'h10014,32'h2);
    rc(17'h10014,32'h2);
    rx_good_bundle=63; repeat(3) p(3'h2);
    rc(17'h112fc,32'h3);
    rc(17'h112fc,32'h0);
    rx_good_bundle=1; sq(0,5); sq(0,11); sq(1,10); sq(2,16'h7fff); sq(2,16'h8000);
    rc(17'h10304,32'h800e);
    bus16=1; rc(17'h10304,32'h800e); bus16=0;
    rx_good_bundle=5; rx_good=1;
    fork rc(17'h11014,32'h2); @(negedge clk) rx_good=0; join
    rc(17'h11014,32'h1);
    rc(17'h12000,32'h0);
    final_report;
  end
endmodule
